// *** dpr_pkg.sv ***
// shared constants and types for the dual-port ram link and its host
package dpr_pkg;
  localparam int ADDR_W = 18;
  localparam int LANES = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = 72;
  localparam int PORTS = 2;
  // mailbox words, index 0 left port, index 1 right port
  localparam logic [17:0] MBOX_L_ADDR = 18'h3fffe;
  localparam logic [17:0] MBOX_R_ADDR = 18'h3ffff;
  localparam logic [1:0][17:0] MBOX_ADDR = {MBOX_R_ADDR, MBOX_L_ADDR};
  // values after global reset
  localparam logic [17:0] CNT_RST = 18'h00000;
  localparam logic [17:0] MASK_RST = 18'h3ffff;
  // clock rate and delay-locked loop settling
  localparam int CLK_MHZ = 100;
  localparam int SLOW_LIMIT_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_NS = 1000;
  localparam int LOCK_CYCLES = (LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LOCK_LAST = 8'(LOCK_CYCLES - 1);
  // host register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA0 = 8'h0c;
  localparam logic [7:0] REG_WDATA1 = 8'h10;
  localparam logic [7:0] REG_WDATA2 = 8'h14;
  localparam logic [7:0] REG_RDATA0 = 8'h18;
  localparam logic [7:0] REG_RDATA1 = 8'h1c;
  localparam logic [7:0] REG_RDATA2 = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_IRQ_STAT = 8'h28;
  localparam logic [7:0] REG_IRQ_CLR = 8'h2c;
  localparam logic [7:0] REG_IRQ_EN = 8'h30;
  // command word fields
  localparam int CMD_GO = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_PORT = 2;
  localparam int CMD_BE_LSB = 4;
  localparam int CMD_CTL_LSB = 12;
  // counter control bits inside the command word field
  localparam int CTL_MSK = 0;
  localparam int CTL_LOAD = 1;
  localparam int CTL_ADV = 2;
  localparam int CTL_CLR = 3;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_COLL = 1;
  localparam int IRQ_MBOX_L = 2;
  localparam int IRQ_MBOX_R = 3;
  localparam int IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ACC = 3'b010,
    H_RD = 3'b100
  } host_state_t;
endpackage

// *** dpr_if.sv ***
// pin-level link between the dual-port ram and its hosts
`timescale 1ns/1ps
`default_nettype none
interface dpr_if;
  logic [1:0][17:0] addr;
  logic [1:0][7:0] byte_lane_enable;
  logic [1:0] chip_select_low_active;
  logic [1:0] chip_select_high_active;
  logic [1:0] read_not_write;
  logic [1:0] output_enable_n;
  logic [1:0] slow_clock_select;
  logic [1:0] counter_or_mask_select;
  logic [1:0] counter_load_strobe;
  logic [1:0] counter_advance_enable;
  logic [1:0] counter_clear;
  logic global_reset_n;
  logic [1:0][71:0] dq_host;
  logic [1:0][7:0] dq_host_oe;
  logic [1:0][71:0] dq_dev;
  logic [1:0][7:0] dq_dev_oe;
  logic [1:0][71:0] dq;
  logic [1:0] busy;
  logic [1:0] ready;
  logic [1:0] mbox_irq_n;
  logic [1:0] counter_wrap_irq_n;
  // resolved data wires per lane; an undriven lane reads as zero
  for (genvar p = 0; p < 2; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_lane
      assign dq[p][b*9 +: 9] = dq_dev_oe[p][b] ? dq_dev[p][b*9 +: 9] :
                               dq_host_oe[p][b] ? dq_host[p][b*9 +: 9] :
                               9'h000;
    end
  end
  modport dev (
    input addr, byte_lane_enable, chip_select_low_active,
    input chip_select_high_active, read_not_write, output_enable_n,
    input slow_clock_select, counter_or_mask_select, counter_load_strobe,
    input counter_advance_enable, counter_clear, global_reset_n, dq,
    output dq_dev, dq_dev_oe, busy, ready, mbox_irq_n, counter_wrap_irq_n
  );
  modport host (
    output addr, byte_lane_enable, chip_select_low_active,
    output chip_select_high_active, read_not_write, output_enable_n,
    output slow_clock_select, counter_or_mask_select, counter_load_strobe,
    output counter_advance_enable, counter_clear, global_reset_n,
    output dq_host, dq_host_oe,
    input dq, busy, ready, mbox_irq_n, counter_wrap_irq_n
  );
endinterface
`default_nettype wire

// *** dpr_device.sv ***
// device end: two-port ram array, mailboxes, burst counters, port status
`timescale 1ns/1ps
`default_nettype none
module dpr_device (
  input wire logic clk_sys_i, // system clock, both ports
  input wire logic resetn_i,  // async reset, active low
  dpr_if.dev link             // pins of both ports
);
  typedef struct packed {
    logic [1:0][17:0] cnt;
    logic [1:0][17:0] mask;
    logic [1:0] rd_valid;
    logic [1:0][7:0] rd_be;
    logic [1:0] busy;
    logic [1:0] ready;
    logic [1:0][7:0] lock;
    logic [1:0] mbox_irq_n;
    logic [1:0] cnt_irq_n;
  } dev_state_t;

  dev_state_t r_reg;
  dev_state_t r_next;
  logic [1:0] sel;
  logic [1:0] mload;
  logic [1:0] acc;
  logic [1:0] wr;
  logic [1:0] rd;
  logic [1:0] any_be;
  logic [1:0][17:0] eff;
  logic [1:0][17:0] inc;
  logic collide;
  logic rst_n;
  logic [dpr_pkg::DATA_W-1:0] mem [0:(1 << dpr_pkg::ADDR_W)-1];
  logic [1:0][dpr_pkg::DATA_W-1:0] rd_data_reg;

  // either reset source acts at once, with no clock needed
  assign rst_n = resetn_i & link.global_reset_n;

  // per-port decode, counters, status
  always_comb begin
    r_next = r_reg;
    for (int p = 0; p < dpr_pkg::PORTS; p++) begin
      // port inputs sampled at the shared clk_sys_i edge
      sel[p] = ~link.chip_select_low_active[p] &
               link.chip_select_high_active[p] &
               r_reg.ready[p];
      mload[p] = sel[p] & link.counter_load_strobe[p] &
                 link.counter_or_mask_select[p];
      acc[p] = sel[p] & ~mload[p];
      any_be[p] = |link.byte_lane_enable[p];
      eff[p] = link.addr[p];
      // only the bits set in the mask count; carries stop at the mask edge
      inc[p] = (r_reg.cnt[p] & ~r_reg.mask[p]) |
               ((r_reg.cnt[p] + 18'h00001) & r_reg.mask[p]);
      if (sel[p] && link.counter_clear[p]) begin
        r_next.cnt[p] = dpr_pkg::CNT_RST;
        r_next.cnt_irq_n[p] = 1'b1;
        eff[p] = dpr_pkg::CNT_RST;
      end else if (mload[p]) begin
        r_next.mask[p] = link.addr[p];
      end else if (sel[p] && link.counter_load_strobe[p]) begin
        r_next.cnt[p] = link.addr[p];
        r_next.cnt_irq_n[p] = 1'b1;
      end else if (sel[p] && link.counter_advance_enable[p]) begin
        eff[p] = r_reg.cnt[p];
        r_next.cnt[p] = inc[p];
        if ((inc[p] & r_reg.mask[p]) == r_reg.mask[p]) begin
          r_next.cnt_irq_n[p] = 1'b0;
        end
      end
      // access type follows the read_not_write level
      wr[p] = acc[p] & ~link.read_not_write[p];
      rd[p] = acc[p] & link.read_not_write[p];
      r_next.rd_valid[p] = rd[p];
      r_next.rd_be[p] = link.byte_lane_enable[p];
      // loop bypassed in slow mode, so the port is usable at once
      if (link.slow_clock_select[p]) begin
        r_next.ready[p] = 1'b1;
      end else if (r_reg.lock[p] == dpr_pkg::LOCK_LAST) begin
        r_next.ready[p] = 1'b1;
      end else begin
        r_next.lock[p] = r_reg.lock[p] + 8'h01;
      end
    end
    // both ports on one word with a write among them
    collide = acc[0] & acc[1] & (eff[0] == eff[1]) & (wr[0] | wr[1]);
    r_next.busy = {2{collide}};
    // mailbox flags: clear first so a same-edge set wins
    for (int p = 0; p < dpr_pkg::PORTS; p++) begin
      if (rd[p] && any_be[p] &&
          eff[p] == dpr_pkg::MBOX_ADDR[p]) begin
        r_next.mbox_irq_n[p] = 1'b1;
      end
      if (wr[1-p] && any_be[1-p] &&
          eff[1-p] == dpr_pkg::MBOX_ADDR[p]) begin
        r_next.mbox_irq_n[p] = 1'b0;
      end
    end
  end

  // state register; global reset restores counters and flags
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.cnt <= {2{dpr_pkg::CNT_RST}};
      r_reg.mask <= {2{dpr_pkg::MASK_RST}};
      r_reg.mbox_irq_n <= 2'b11;
      r_reg.cnt_irq_n <= 2'b11;
    end else begin
      r_reg <= r_next;
    end
  end

  // array: right port written last, so it wins a same-word clash;
  // the stored value is undefined by contract, hosts avoid it
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < dpr_pkg::PORTS; p++) begin
      if (rd[p]) begin
        rd_data_reg[p] <= mem[eff[p]];
      end
      if (wr[p]) begin
        for (int b = 0; b < dpr_pkg::LANES; b++) begin
          if (link.byte_lane_enable[p][b]) begin
            mem[eff[p]][b*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] <=
              link.dq[p][b*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
          end
        end
      end
    end
  end

  // read data, lane by lane; the enable path has no flop on purpose
  assign link.dq_dev = rd_data_reg;
  for (genvar p = 0; p < 2; p++) begin : g_oe
    assign link.dq_dev_oe[p] = r_reg.rd_be[p] &
      {8{r_reg.rd_valid[p] & ~link.output_enable_n[p]}};
  end

  // status pins straight from the state register
  assign link.busy = r_reg.busy;
  assign link.ready = r_reg.ready;
  assign link.mbox_irq_n = r_reg.mbox_irq_n;
  assign link.counter_wrap_irq_n = r_reg.cnt_irq_n;
endmodule
`default_nettype wire

// *** dpr_host.sv ***
// host end: AXI4-Lite command registers driving both ram ports
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
  input wire logic clk_sys_i,        // system clock
  input wire logic resetn_i,         // async reset, active low
  input wire logic [7:0] awaddr_i,   // write address
  input wire logic awvalid_i,        // write address valid
  output logic awready_o,            // write address ready
  input wire logic [31:0] wdata_i,   // write data
  input wire logic [3:0] wstrb_i,    // write strobes, not used
  input wire logic wvalid_i,         // write data valid
  output logic wready_o,             // write data ready
  output logic [1:0] bresp_o,        // write response
  output logic bvalid_o,             // write response valid
  input wire logic bready_i,         // write response ready
  input wire logic [7:0] araddr_i,   // read address
  input wire logic arvalid_i,        // read address valid
  output logic arready_o,            // read address ready
  output logic [31:0] rdata_o,       // read data
  output logic [1:0] rresp_o,        // read response
  output logic rvalid_o,             // read data valid
  input wire logic rready_i,         // read data ready
  output logic irq_o,                // interrupt, active high level
  dpr_if.host link                   // ram pins of both ports
);
  typedef struct packed {
    dpr_pkg::host_state_t st;
    logic port;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [17:0] addr;
    logic [71:0] wbuf;
    logic [71:0] rbuf;
    logic grst;
    logic [3:0] irq_stat, irq_en;
    logic irq;
    logic [1:0] mbox_prev;
    logic [1:0][17:0] p_addr;
    logic [1:0][7:0] p_be;
    logic [1:0] csl, csh, rnw, oe_n, slow;
    logic [1:0][3:0] ctl;
    logic [1:0][71:0] dq;
    logic [1:0][7:0] dq_oe;
  } host_state_t;

  host_state_t r_reg;
  host_state_t r_next;
  logic go;
  logic pt;
  logic [3:0] ev;
  logic [3:0] clr;

  always_comb begin
    r_next = r_reg;
    go = 1'b0;
    clr = 4'h0;
    pt = r_reg.wdata[dpr_pkg::CMD_PORT];
    // write channels are taken in either order, then applied together
    if (awvalid_i && r_reg.awready) begin
      r_next.aw_ok = 1'b1;
      r_next.awaddr = awaddr_i;
    end
    if (wvalid_i && r_reg.wready) begin
      r_next.w_ok = 1'b1;
      r_next.wdata = wdata_i;
    end
    if (r_reg.bvalid && bready_i) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid) begin
      r_next.aw_ok = 1'b0;
      r_next.w_ok = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = dpr_pkg::RESP_OKAY;
      if (r_reg.awaddr == dpr_pkg::REG_CMD) begin
        go = r_reg.wdata[dpr_pkg::CMD_GO];
      end else if (r_reg.awaddr == dpr_pkg::REG_CTRL) begin
        r_next.grst = r_reg.wdata[0];
      end else if (r_reg.awaddr == dpr_pkg::REG_ADDR) begin
        r_next.addr = r_reg.wdata[17:0];
      end else if (r_reg.awaddr == dpr_pkg::REG_WDATA0) begin
        r_next.wbuf[31:0] = r_reg.wdata;
      end else if (r_reg.awaddr == dpr_pkg::REG_WDATA1) begin
        r_next.wbuf[63:32] = r_reg.wdata;
      end else if (r_reg.awaddr == dpr_pkg::REG_WDATA2) begin
        r_next.wbuf[71:64] = r_reg.wdata[7:0];
      end else if (r_reg.awaddr == dpr_pkg::REG_IRQ_CLR) begin
        clr = r_reg.wdata[3:0];
      end else if (r_reg.awaddr == dpr_pkg::REG_IRQ_EN) begin
        r_next.irq_en = r_reg.wdata[3:0];
      end else begin
        r_next.bresp = dpr_pkg::RESP_SLVERR;
      end
    end
    r_next.awready = ~r_next.aw_ok & ~r_next.bvalid;
    r_next.wready = ~r_next.w_ok & ~r_next.bvalid;
    // read channel: one answer outstanding at a time
    if (r_reg.rvalid && rready_i) begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end
    if (arvalid_i && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.arready = 1'b0;
      r_next.rresp = dpr_pkg::RESP_OKAY;
      r_next.rdata = 32'h00000000;
      if (araddr_i == dpr_pkg::REG_CTRL) begin
        r_next.rdata = {31'h00000000, r_reg.grst};
      end else if (araddr_i == dpr_pkg::REG_ADDR) begin
        r_next.rdata = {14'h0000, r_reg.addr};
      end else if (araddr_i == dpr_pkg::REG_RDATA0) begin
        r_next.rdata = r_reg.rbuf[31:0];
      end else if (araddr_i == dpr_pkg::REG_RDATA1) begin
        r_next.rdata = r_reg.rbuf[63:32];
      end else if (araddr_i == dpr_pkg::REG_RDATA2) begin
        r_next.rdata = {24'h000000, r_reg.rbuf[71:64]};
      end else if (araddr_i == dpr_pkg::REG_STATUS) begin
        r_next.rdata = {23'h000000, link.busy, link.counter_wrap_irq_n,
                        link.mbox_irq_n, link.ready,
                        r_reg.st != dpr_pkg::H_IDLE};
      end else if (araddr_i == dpr_pkg::REG_IRQ_STAT) begin
        r_next.rdata = {28'h0000000, r_reg.irq_stat};
      end else if (araddr_i == dpr_pkg::REG_IRQ_EN) begin
        r_next.rdata = {28'h0000000, r_reg.irq_en};
      end else begin
        r_next.rresp = dpr_pkg::RESP_SLVERR;
      end
    end
    // one access at a time, so both ports never write together
    ev = 4'h0;
    case (r_reg.st)
      dpr_pkg::H_IDLE: begin
        if (go && link.ready[pt]) begin
          r_next.port = pt;
          r_next.p_addr[pt] = r_reg.addr;
          r_next.p_be[pt] = r_reg.wdata[dpr_pkg::CMD_BE_LSB +: 8];
          r_next.ctl[pt] = r_reg.wdata[dpr_pkg::CMD_CTL_LSB +: 4];
          r_next.csl[pt] = 1'b0;
          r_next.csh[pt] = 1'b1;
          r_next.rnw[pt] = r_reg.wdata[dpr_pkg::CMD_RD];
          r_next.dq[pt] = r_reg.wbuf;
          if (!r_reg.wdata[dpr_pkg::CMD_RD]) begin
            r_next.dq_oe[pt] = r_reg.wdata[dpr_pkg::CMD_BE_LSB +: 8];
          end
          r_next.st = dpr_pkg::H_ACC;
        end
      end
      dpr_pkg::H_ACC: begin
        r_next.csl[r_reg.port] = 1'b1;
        r_next.csh[r_reg.port] = 1'b0;
        r_next.ctl[r_reg.port] = 4'h0;
        r_next.dq_oe[r_reg.port] = 8'h00;
        if (r_reg.rnw[r_reg.port]) begin
          r_next.oe_n[r_reg.port] = 1'b0;
          r_next.st = dpr_pkg::H_RD;
        end else begin
          ev[dpr_pkg::IRQ_DONE] = 1'b1;
          r_next.st = dpr_pkg::H_IDLE;
        end
      end
      dpr_pkg::H_RD: begin
        r_next.rbuf = link.dq[r_reg.port];
        r_next.oe_n[r_reg.port] = 1'b1;
        ev[dpr_pkg::IRQ_DONE] = 1'b1;
        r_next.st = dpr_pkg::H_IDLE;
      end
      default: begin
        r_next.st = dpr_pkg::H_IDLE;
      end
    endcase
    // clock is fixed, so the slow select is a constant level
    r_next.slow = {2{dpr_pkg::CLK_MHZ < dpr_pkg::SLOW_LIMIT_MHZ}};
    // sticky events; a new event beats a clear in the same cycle
    ev[dpr_pkg::IRQ_COLL] = |link.busy;
    ev[dpr_pkg::IRQ_MBOX_L] = r_reg.mbox_prev[0] & ~link.mbox_irq_n[0];
    ev[dpr_pkg::IRQ_MBOX_R] = r_reg.mbox_prev[1] & ~link.mbox_irq_n[1];
    r_next.mbox_prev = link.mbox_irq_n;
    r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
    r_next.irq = |(r_next.irq_stat & r_next.irq_en);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
      r_reg.st <= dpr_pkg::H_IDLE;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
      r_reg.csl <= 2'b11;
      r_reg.oe_n <= 2'b11;
      r_reg.mbox_prev <= 2'b11;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign awready_o = r_reg.awready;
  assign wready_o = r_reg.wready;
  assign bvalid_o = r_reg.bvalid;
  assign bresp_o = r_reg.bresp;
  assign arready_o = r_reg.arready;
  assign rvalid_o = r_reg.rvalid;
  assign rdata_o = r_reg.rdata;
  assign rresp_o = r_reg.rresp;
  assign irq_o = r_reg.irq;
  assign link.addr = r_reg.p_addr;
  assign link.byte_lane_enable = r_reg.p_be;
  assign link.chip_select_low_active = r_reg.csl;
  assign link.chip_select_high_active = r_reg.csh;
  assign link.read_not_write = r_reg.rnw;
  assign link.output_enable_n = r_reg.oe_n;
  assign link.slow_clock_select = r_reg.slow;
  assign link.counter_or_mask_select = {r_reg.ctl[1][0], r_reg.ctl[0][0]};
  assign link.counter_load_strobe = {r_reg.ctl[1][1], r_reg.ctl[0][1]};
  assign link.counter_advance_enable = {r_reg.ctl[1][2], r_reg.ctl[0][2]};
  assign link.counter_clear = {r_reg.ctl[1][3], r_reg.ctl[0][3]};
  assign link.global_reset_n = ~r_reg.grst;
  assign link.dq_host = r_reg.dq;
  assign link.dq_host_oe = r_reg.dq_oe;
endmodule
`default_nettype wire

// *** dpr_asserts.sv ***
// concurrent checks on the pins between the ram and its host
`timescale 1ns/1ps
`default_nettype none
module dpr_asserts (
  input wire logic clk_sys_i, // clock
  input wire logic resetn_i, // async reset
  input wire logic [1:0][17:0] addr, // address
  input wire logic [1:0][7:0] byte_lane_enable, // lanes
  input wire logic [1:0] chip_select_low_active, // select low
  input wire logic [1:0] chip_select_high_active, // select high
  input wire logic [1:0] read_not_write, // 1 read
  input wire logic [1:0] output_enable_n, // data drive
  input wire logic [1:0] slow_clock_select, // dll bypass
  input wire logic global_reset_n, // device reset
  input wire logic [1:0][7:0] dq_dev_oe, // device drive
  input wire logic [1:0] busy, // collision
  input wire logic [1:0] ready, // port ready
  input wire logic [1:0] mbox_irq_n, // mailbox flags
  input wire logic [1:0] counter_wrap_irq_n // counter flags
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] sel;
  logic [7:0] since_reg;
  assign sel = ~chip_select_low_active & chip_select_high_active;
  // edges since either reset; saturates so a long run never wraps
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) since_reg <= 8'h00;
    else if (!global_reset_n) since_reg <= 8'h00;
    else if (since_reg != 8'hff) since_reg <= since_reg + 8'h01;
  end
  for (genvar p = 0; p < 2; p++) begin : g_port
    // other port writes this port's mailbox with a lane on
    sequence mbox_write;
      sel[1-p] && !read_not_write[1-p] && ready[1-p] &&
        addr[1-p] == dpr_pkg::MBOX_ADDR[p] && byte_lane_enable[1-p] != 8'h00;
    endsequence
    sequence mbox_read;
      sel[p] && read_not_write[p] && ready[p] &&
        addr[p] == dpr_pkg::MBOX_ADDR[p] && byte_lane_enable[p] != 8'h00;
    endsequence
    sequence read_taken;
      sel[p] && read_not_write[p] && ready[p];
    endsequence
    oe_needs_low_a: assert property (dq_dev_oe[p] != 8'h00 |-> !output_enable_n[p]) else $error("data driven with enable high");
    read_lanes_a: assert property (read_taken ##1 !output_enable_n[p] |-> dq_dev_oe[p] == $past(byte_lane_enable[p])) else $error("read lanes wrong");
    mbox_set_a: assert property (mbox_write |=> !mbox_irq_n[p]) else $error("mailbox flag not set");
    mbox_clear_a: assert property (mbox_read |=> mbox_irq_n[p]) else $error("mailbox flag not cleared");
    busy_needs_select_a: assert property (busy[p] |-> $past(sel == 2'b11)) else $error("busy without two accesses");
    ready_lock_time_a: assert property ($rose(ready[p]) && !slow_clock_select[p] |-> since_reg == 8'(dpr_pkg::LOCK_CYCLES)) else $error("ready at wrong time");
    select_pulse_a: assert property (sel[p] |=> !sel[p]) else $error("select held too long");
  end
  greset_flags_a: assert property (!global_reset_n |-> mbox_irq_n == 2'b11 && counter_wrap_irq_n == 2'b11 && ready == 2'b00) else $error("global reset state wrong");
endmodule
`default_nettype wire

// *** dual_port_ram_port_interface_bench.sv ***
// self-checking bench: axi host driving both ram ports
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_port_interface_bench;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] mask;
    logic [31:0] data;
  } exp_t;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [17:0] a;
  logic [71:0] d;
  logic [71:0] mem [logic [17:0]];
  int failures = 0, checks_done = 0, n;
  int seed = 32'h6b5be68e;
  exp_t rq[$], e;
  logic [1:0] bq[$];
  always #5 clk_sys_i = ~clk_sys_i;
  dpr_if dpr_if_inst();
  dpr_device dpr_device_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .link(dpr_if_inst.dev));
  dpr_host dpr_host_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready_o),
    .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready), .irq_o(irq_o), .link(dpr_if_inst.host));
  dpr_asserts dpr_asserts_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .addr(dpr_if_inst.addr), .byte_lane_enable(dpr_if_inst.byte_lane_enable),
    .chip_select_low_active(dpr_if_inst.chip_select_low_active),
    .chip_select_high_active(dpr_if_inst.chip_select_high_active),
    .read_not_write(dpr_if_inst.read_not_write),
    .output_enable_n(dpr_if_inst.output_enable_n),
    .slow_clock_select(dpr_if_inst.slow_clock_select),
    .global_reset_n(dpr_if_inst.global_reset_n),
    .dq_dev_oe(dpr_if_inst.dq_dev_oe), .busy(dpr_if_inst.busy),
    .ready(dpr_if_inst.ready), .mbox_irq_n(dpr_if_inst.mbox_irq_n),
    .counter_wrap_irq_n(dpr_if_inst.counter_wrap_irq_n));
  task automatic cmp(input string s, input logic [33:0] ex,
                     input logic [33:0] v);
    checks_done++;
    if (v !== ex) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, ex, v);
    end
  endtask
  // oldest note against each response as it is taken
  always @(posedge clk_sys_i) begin
    if (rvalid_o === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      cmp("rdata", {e.resp, e.data}, {rresp_o, rdata_o & e.mask});
    end
    if (bvalid_o === 1'b1 && bready === 1'b1)
      cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp_o});
  end
  // one axi transfer; valids drop on their own handshake edge
  task automatic bus(input bit rd, input logic [7:0] ad, input logic [31:0] dt,
                     input logic [1:0] r, input logic [31:0] m);
    @(posedge clk_sys_i);
    if (rd) rq.push_back('{r, m, dt & m});
    else bq.push_back(r);
    awaddr <= ad;
    araddr <= ad;
    wdata <= dt;
    awvalid <= !rd;
    wvalid <= !rd;
    arvalid <= rd;
    bready <= !rd;
    rready <= rd;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (awready_o === 1'b1) awvalid <= 1'b0;
      if (wready_o === 1'b1) wvalid <= 1'b0;
      if (arready_o === 1'b1) arvalid <= 1'b0;
    end while ((rd ? rvalid_o : bvalid_o) !== 1'b1 && n < 99);
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 99) cmp("bus_answer", 34'h1, 34'h0);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    bus(1'b0, ad, dt, 2'b00, 32'h0);
  endtask
  // one port access via the command word; done comes back as irq
  task automatic acc(input bit p, input bit rd, input logic [17:0] ad,
                     input logic [7:0] be, input logic [71:0] dt);
    logic [71:0] m;
    int k;
    for (int b = 0; b < 8; b++) m[b*9 +: 9] = {9{be[b]}};
    if (!mem.exists(ad)) mem[ad] = 'x;
    wr(dpr_pkg::REG_ADDR, 32'(ad));
    if (!rd) begin
      wr(dpr_pkg::REG_WDATA0, dt[31:0]);
      wr(dpr_pkg::REG_WDATA1, dt[63:32]);
      wr(dpr_pkg::REG_WDATA2, 32'(dt[71:64]));
      mem[ad] = (mem[ad] & ~m) | (dt & m);
    end
    wr(dpr_pkg::REG_CMD, {20'h0, be, 1'b0, p, rd, 1'b1});
    k = 0;
    while (irq_o !== 1'b1 && k < 50) begin
      @(posedge clk_sys_i);
      k++;
    end
    cmp("irq_o", 34'h1, 34'(irq_o));
    wr(dpr_pkg::REG_IRQ_CLR, 32'h1);
    // lanes switched off read back as zero: nobody drives them
    m = mem[ad] & m;
    if (rd) begin
      bus(1'b1, dpr_pkg::REG_RDATA0, m[31:0], 2'b00, '1);
      bus(1'b1, dpr_pkg::REG_RDATA1, m[63:32], 2'b00, '1);
      bus(1'b1, dpr_pkg::REG_RDATA2, 32'(m[71:64]), 2'b00, '1);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    bus(1'b1, dpr_pkg::REG_STATUS, 32'h78, 2'b00, 32'h1ff);
    repeat (dpr_pkg::LOCK_CYCLES) @(posedge clk_sys_i);
    bus(1'b1, dpr_pkg::REG_STATUS, 32'h7e, 2'b00, 32'h1ff);
    // unmapped, write-only and read-only places are refused; then the done interrupt is enabled
    bus(1'b1, 8'h40, 32'h0, 2'b10, '1);
    bus(1'b1, dpr_pkg::REG_CMD, 32'h0, 2'b10, '1);
    bus(1'b0, dpr_pkg::REG_STATUS, 32'h0, 2'b10, '0);
    bus(1'b0, 8'h44, 32'h0, 2'b10, '0);
    wr(dpr_pkg::REG_IRQ_EN, 32'h1);
    // random words written on one port, read on the other, then partial-lane writes and reads of one word on both ports
    for (int i = 0; i < 6; i++) begin
      a = 18'($random(seed)) & 18'h0ffff;
      d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      acc(i[0], 1'b0, a, 8'hff, d);
      acc(!i[0], 1'b1, a, 8'hff, d);
    end
    acc(1'b0, 1'b0, 18'h00123, 8'hff, '1);
    acc(1'b1, 1'b0, 18'h00123, 8'h5a, '0);
    acc(1'b0, 1'b1, 18'h00123, 8'hff, d);
    acc(1'b1, 1'b1, 18'h00123, 8'h0f, d);
    // each mailbox flag falls on the other's write, rises on own read
    for (int p = 0; p < 2; p++) begin
      acc(!p[0], 1'b0, dpr_pkg::MBOX_ADDR[p], 8'h00, d);
      bus(1'b1, dpr_pkg::REG_STATUS, 32'h18, 2'b00, 32'h18);
      acc(!p[0], 1'b0, dpr_pkg::MBOX_ADDR[p], 8'h01, d);
      bus(1'b1, dpr_pkg::REG_STATUS, 32'h18 ^ (32'h8 << p), 2'b00, 32'h18);
      bus(1'b1, dpr_pkg::REG_IRQ_STAT, 32'h4 << p, 2'b00, 32'h4 << p);
      acc(p[0], 1'b1, dpr_pkg::MBOX_ADDR[p], 8'h01, d);
      bus(1'b1, dpr_pkg::REG_STATUS, 32'h18, 2'b00, 32'h18);
    end
    // global reset with a flag low: flags forced high, ports relock
    acc(1'b0, 1'b0, dpr_pkg::MBOX_ADDR[1], 8'h01, d);
    wr(dpr_pkg::REG_CTRL, 32'h1);
    bus(1'b1, dpr_pkg::REG_STATUS, 32'h78, 2'b00, 32'h1ff);
    wr(dpr_pkg::REG_CTRL, 32'h0);
    repeat (dpr_pkg::LOCK_CYCLES) @(posedge clk_sys_i);
    bus(1'b1, dpr_pkg::REG_STATUS, 32'h7e, 2'b00, 32'h1ff);
    // wrap flag after load and advance
    wr(dpr_pkg::REG_ADDR, 32'h3fffe);
    wr(dpr_pkg::REG_CMD, 32'h2003);
    wr(dpr_pkg::REG_CMD, 32'h4003);
    bus(1'b1, dpr_pkg::REG_STATUS, 32'h58, 2'b00, 32'h1f8);
    // done stays in status while masked; the line follows the enable
    wr(dpr_pkg::REG_IRQ_CLR, 32'hf);
    wr(dpr_pkg::REG_IRQ_EN, 32'h0);
    wr(dpr_pkg::REG_CMD, 32'h11);
    bus(1'b1, dpr_pkg::REG_IRQ_STAT, 32'h1, 2'b00, 32'h1);
    cmp("irq_o", 34'h0, 34'(irq_o));
    wr(dpr_pkg::REG_IRQ_EN, 32'h1);
    @(posedge clk_sys_i);
    cmp("irq_o", 34'h1, 34'(irq_o));
    wr(dpr_pkg::REG_IRQ_CLR, 32'h1);
    @(posedge clk_sys_i);
    cmp("irq_o", 34'h0, 34'(irq_o));
    results();
  end
  // whole run is about a thousand cycles; this is far beyond it
  initial begin
    #200us;
    $display("ERROR watchdog expected 1 seen 0");
    failures++;
    results();
  end
endmodule
`default_nettype wire
